// ===== hlpf_pkg.sv
// Purpose: Shared constants of the headerless packet framer.
// Assumes: 10 MHz clock, 28 byte-wide configuration registers.
// Notes: Offsets are register indices.
package hlpf_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam int NUM_REGS = 28;
    localparam logic [4:0] OFF_LOCAL = 5'h00;
    localparam logic [4:0] OFF_DEST = 5'h02;
    localparam logic [4:0] OFF_MODE = 5'h03;
    localparam logic [4:0] OFF_RPT = 5'h0d;
    localparam logic [4:0] OFF_TERM1 = 5'h10;
    localparam logic [4:0] OFF_TERM2 = 5'h11;
    localparam logic [4:0] OFF_COMM1 = 5'h12;
    localparam logic [4:0] OFF_COMM2 = 5'h13;
    localparam logic [4:0] OFF_IF4 = 5'h17;
    localparam logic [7:0] RST_DEST = 8'h00;
    localparam logic [7:0] RST_MODE = 8'hf0;
    localparam logic [7:0] RST_RPT = 8'h1e;
    localparam logic [7:0] RST_TERM1 = 8'h32;
    localparam logic [7:0] RST_TERM2 = 8'h32;
    localparam logic [7:0] RST_COMM1 = 8'h8c;
    localparam logic [7:0] RST_IF4 = 8'h00;
    localparam logic [7:0] RST_OTHER = 8'h00;
    localparam logic [7:0] COMM1_WMASK = 8'h3f;
    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int C1_DEST_CHK = 0;
    localparam int C1_SRC_CHK = 1;
    localparam int C1_TERM_LO = 2;
    localparam int C1_FORMAT = 4;
    localparam int C1_PATH = 5;
    localparam int C2_REPEATER = 0;
    localparam int IF4_CRLF = 4;
    localparam int FLG_BINARY = 0;
    localparam int FLG_HEADERLESS = 1;
    // --------------------------------------------------------------
    // Values and timing
    // --------------------------------------------------------------
    localparam logic [7:0] MODE_HEADERLESS = 8'hff;
    localparam logic [7:0] DEST_MAX = 8'hef;
    localparam logic [7:0] DEST_BROADCAST = 8'hff;
    localparam logic [7:0] MAX_LEN = 8'hff;
    localparam logic [7:0] CHAR_CR = 8'h0d;
    localparam logic [7:0] CHAR_LF = 8'h0a;
    localparam logic [1:0] TERM_EITHER = 2'h0;
    localparam logic [1:0] TERM_WILD = 2'h1;
    localparam logic [1:0] TERM_PAIR = 2'h2;
    localparam logic [1:0] TERM_CRLF = 2'h3;
    localparam int CLK_HZ = 10_000_000;
    localparam int TIMEOUT_SEC = 5;
    localparam int TIMEOUT_CYC = TIMEOUT_SEC * CLK_HZ;
    localparam int RETRY_COUNT = 3;
endpackage : hlpf_pkg

// ===== hlpf_term_if.sv
// Purpose: Carries host bytes and terminator settings to the detector.
// Assumes: One clock domain.
// Notes: hit is combinational on the current byte.
`timescale 1ns/1ps
interface hlpf_term_if;
    logic byteValid;
    logic [7:0] byteData;
    logic [1:0] mode;
    logic [7:0] first;
    logic [7:0] second;
    logic clear;
    logic hit;
    modport detector (input byteValid, byteData, mode, first, second, clear, output hit);
    modport user (output byteValid, byteData, mode, first, second, clear, input hit);
endinterface : hlpf_term_if

// ===== hlpf_term_detect.sv
// Purpose: Terminator detection on the host byte stream.
// Assumes: Bytes arrive one per valid cycle.
// Notes: Armed state remembers a matched first byte.
`timescale 1ns/1ps
module hlpf_term_detect (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Detector side
    hlpf_term_if.detector term
);
    logic armed_q;
    logic armed_d;
    wire crlf = term.mode == hlpf_pkg::TERM_CRLF;
    wire matchFirst = term.byteData == (crlf ? hlpf_pkg::CHAR_CR : term.first);
    wire matchSecond = term.byteData == (crlf ? hlpf_pkg::CHAR_LF : term.second);
    wire hitEither = matchFirst | matchSecond; // [R24]
    wire hitWild = armed_q; // [R23]
    wire hitPair = armed_q & matchSecond; // [R5] [R6]
    assign term.hit = term.byteValid & ((term.mode == hlpf_pkg::TERM_EITHER) ? hitEither :
                      (term.mode == hlpf_pkg::TERM_WILD) ? hitWild : hitPair); // [R12]
    assign armed_d = term.clear ? 1'b0 :
                     term.byteValid ? (!term.hit && term.mode != hlpf_pkg::TERM_EITHER && matchFirst) :
                     armed_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
        end
    end
endmodule : hlpf_term_detect

// ===== hlpf_framer.sv
// Purpose: Frames host bytes into radio packets and delivers received packets.
// Assumes: Radio side accepts header then data bytes; host output never stalls.
// Notes: Registers are reached by the register port and the two commands.
// Function
// [R1] Destination accepted only 0 to 239, or 255 for broadcast
// [R2] Destination address inserted into every packet
// [R3] Set-destination command overwrites destination
// [R4] Mode value FFH selects headerless mode
// [R5] Two-byte terminator first byte from register
// [R6] Two-byte terminator last byte from register
// [R7] Fixed five second input timeout
// [R8] Path bit selects direct or repeater
// [R9] Repeater route uses repeater address register
// [R10] Format bit tags text or binary
// [R11] Format tag ignored by headerless receiver
// [R12] Two-bit field selects terminator kind
// [R13] Terminator ends packet, packet transmitted
// [R14] Destination and source address check enables
// [R15] Headerless: bit set appends CR LF
// [R16] Normal mode: bit clear appends CR LF
// [R17] Headerless pair: append setting ineffective
// [R18] Read-all returns all 28 registers
// [R19] Setting-two bit 0 makes device repeater
// [R20] Over 255 bytes flags command error
// [R21] CTS off during transmission
// [R22] Broadcast 255 sent retries plus one
// [R23] Wildcard ends on byte after first
// [R24] Either single byte ends packet
`timescale 1ns/1ps
module hlpf_framer #(
    parameter int TIMEOUT_CYCLES = hlpf_pkg::TIMEOUT_CYC,
    parameter int RETRIES = hlpf_pkg::RETRY_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port and commands
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic setDestValid,
    input wire logic [7:0] setDestAddr,
    input wire logic readAllCmd,
    output logic [7:0] regRdata,
    output logic regRdValid,
    output logic cmdOk,
    output logic cmdError,
    // Host byte stream
    input wire logic hostValid,
    input wire logic [7:0] hostData,
    output logic clearToSend,
    output logic hostOutValid,
    output logic [7:0] hostOutData,
    output logic rxBinary,
    // Radio transmit
    output logic pktValid,
    output logic [7:0] pktData,
    output logic pktLast,
    input wire logic pktReady,
    // Radio receive
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxFirst,
    input wire logic rxLast,
    output logic rxReady,
    // Status
    output logic headerless,
    output logic repeaterRole
);
    typedef enum logic [2:0] {ST_COLLECT, ST_DEST, ST_RPT, ST_FMT, ST_DATA, ST_DONE} hlpf_tx_t;
    typedef enum logic [2:0] {RX_DEST, RX_SRC, RX_FLAGS, RX_DATA, RX_CR, RX_LF} hlpf_rx_t;

    function automatic logic validDest(input logic [7:0] b);
        validDest = (b <= hlpf_pkg::DEST_MAX) || (b == hlpf_pkg::DEST_BROADCAST);
    endfunction : validDest

    function automatic logic [7:0] regReset(input int i);
        case (i)
            hlpf_pkg::OFF_DEST: regReset = hlpf_pkg::RST_DEST;
            hlpf_pkg::OFF_MODE: regReset = hlpf_pkg::RST_MODE;
            hlpf_pkg::OFF_RPT: regReset = hlpf_pkg::RST_RPT;
            hlpf_pkg::OFF_TERM1: regReset = hlpf_pkg::RST_TERM1;
            hlpf_pkg::OFF_TERM2: regReset = hlpf_pkg::RST_TERM2;
            hlpf_pkg::OFF_COMM1: regReset = hlpf_pkg::RST_COMM1;
            hlpf_pkg::OFF_IF4: regReset = hlpf_pkg::RST_IF4;
            default: regReset = hlpf_pkg::RST_OTHER;
        endcase
    endfunction : regReset

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [7:0] regs_q [hlpf_pkg::NUM_REGS];
    logic [4:0] readIdx_q;
    logic readAll_q;
    wire regWrHit = regWrite && (regAddr < 5'(hlpf_pkg::NUM_REGS));
    wire destWrite = setDestValid || (regWrHit && regAddr == hlpf_pkg::OFF_DEST);
    wire [7:0] destValue = setDestValid ? setDestAddr : regWdata;
    wire destOk = validDest(destValue); // [R1] [R22]
    wire [7:0] comm1 = regs_q[hlpf_pkg::OFF_COMM1];
    wire [7:0] localAddr = regs_q[hlpf_pkg::OFF_LOCAL];
    wire [7:0] destReg = regs_q[hlpf_pkg::OFF_DEST];
    wire isHeaderless = regs_q[hlpf_pkg::OFF_MODE] == hlpf_pkg::MODE_HEADERLESS; // [R4]
    wire readAllLast = readIdx_q == 5'(hlpf_pkg::NUM_REGS - 1);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < hlpf_pkg::NUM_REGS; i++) begin
                regs_q[i] <= regReset(i);
            end
        end else begin
            for (int i = 0; i < hlpf_pkg::NUM_REGS; i++) begin
                if (regWrHit && regAddr == 5'(i) && regAddr != hlpf_pkg::OFF_DEST) begin
                    regs_q[i] <= (regAddr == hlpf_pkg::OFF_COMM1) ?
                        ((regs_q[i] & ~hlpf_pkg::COMM1_WMASK) | (regWdata & hlpf_pkg::COMM1_WMASK)) : regWdata;
                end
            end
            if (destWrite && destOk) begin
                regs_q[hlpf_pkg::OFF_DEST] <= destValue; // [R3]
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readAll_q <= 1'b0;
            readIdx_q <= 5'h00;
            regRdata <= 8'h00;
            regRdValid <= 1'b0;
            cmdOk <= 1'b0;
        end else begin
            cmdOk <= (setDestValid && destOk) || (readAll_q && readAllLast);
            regRdValid <= readAll_q || regRead;
            if (readAll_q) begin
                regRdata <= regs_q[readIdx_q]; // [R18]
                readIdx_q <= readIdx_q + 5'h01;
                readAll_q <= !readAllLast;
            end else begin
                regRdata <= (regAddr < 5'(hlpf_pkg::NUM_REGS)) ? regs_q[regAddr] : 8'h00;
                readIdx_q <= 5'h00;
                readAll_q <= readAllCmd;
            end
        end
    end

    // ------------------------------------------------------------------
    // Terminator detection and collection
    // ------------------------------------------------------------------
    hlpf_term_if term ();
    logic [7:0] buf_q [hlpf_pkg::MAX_LEN];
    logic [7:0] len_q;
    logic [7:0] txLen_q;
    logic [7:0] rdIdx_q;
    logic [31:0] idle_q;
    logic [7:0] txDest_q;
    logic [7:0] rounds_q;
    hlpf_tx_t tx_q;
    wire take = hostValid && clearToSend && tx_q == ST_COLLECT;
    wire overflow = take && len_q == hlpf_pkg::MAX_LEN; // [R20]
    wire timedOut = (len_q != 8'h00) && (idle_q >= 32'(TIMEOUT_CYCLES - 1)); // [R7]
    wire pktAdvance = !pktValid || pktReady;
    wire lastData = rdIdx_q == txLen_q - 8'h01;
    wire viaRepeater = comm1[hlpf_pkg::C1_PATH]; // [R8]
    wire [7:0] txFlags = {6'h00, isHeaderless, comm1[hlpf_pkg::C1_FORMAT]}; // [R10]

    assign term.byteValid = take && !overflow;
    assign term.byteData = hostData;
    assign term.mode = comm1[hlpf_pkg::C1_TERM_LO +: 2];
    assign term.first = regs_q[hlpf_pkg::OFF_TERM1];
    assign term.second = regs_q[hlpf_pkg::OFF_TERM2];
    assign term.clear = overflow || timedOut;

    hlpf_term_detect detect (
        .clk(clk),
        .resetn(resetn),
        .term(term)
    );

    always_ff @(posedge clk) begin
        if (take && !overflow) begin
            buf_q[len_q] <= hostData;
        end
    end

    // ------------------------------------------------------------------
    // Transmit sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_q <= ST_COLLECT;
            len_q <= 8'h00;
            txLen_q <= 8'h00;
            rdIdx_q <= 8'h00;
            idle_q <= 32'h0;
            txDest_q <= 8'h00;
            rounds_q <= 8'h00;
            clearToSend <= 1'b0;
            cmdError <= 1'b0;
            pktValid <= 1'b0;
            pktData <= 8'h00;
            pktLast <= 1'b0;
        end else begin
            cmdError <= overflow || (destWrite && !destOk);
            unique case (tx_q)
                ST_COLLECT: begin
                    clearToSend <= isHeaderless;
                    idle_q <= (take || len_q == 8'h00) ? 32'h0 : idle_q + 32'h1;
                    if (overflow || timedOut) begin
                        len_q <= 8'h00;
                    end else if (term.hit) begin
                        txLen_q <= len_q + 8'h01; // [R13]
                        len_q <= 8'h00;
                        txDest_q <= destReg;
                        rounds_q <= (destReg == hlpf_pkg::DEST_BROADCAST) ? 8'(RETRIES) : 8'h00; // [R22]
                        clearToSend <= 1'b0; // [R21]
                        tx_q <= ST_DEST;
                    end else if (take) begin
                        len_q <= len_q + 8'h01;
                    end
                end
                ST_DEST: if (pktAdvance) begin
                    pktValid <= 1'b1;
                    pktData <= txDest_q; // [R2]
                    pktLast <= 1'b0;
                    rdIdx_q <= 8'h00;
                    tx_q <= viaRepeater ? ST_RPT : ST_FMT;
                end
                ST_RPT: if (pktAdvance) begin
                    pktData <= regs_q[hlpf_pkg::OFF_RPT]; // [R9]
                    tx_q <= ST_FMT;
                end
                ST_FMT: if (pktAdvance) begin
                    pktData <= txFlags;
                    tx_q <= ST_DATA;
                end
                ST_DATA: if (pktAdvance) begin
                    pktData <= buf_q[rdIdx_q];
                    pktLast <= lastData;
                    rdIdx_q <= rdIdx_q + 8'h01;
                    if (lastData) begin
                        tx_q <= (rounds_q != 8'h00) ? ST_DEST : ST_DONE;
                        rounds_q <= rounds_q - ((rounds_q != 8'h00) ? 8'h01 : 8'h00);
                    end
                end
                ST_DONE: if (pktReady) begin
                    pktValid <= 1'b0;
                    pktLast <= 1'b0;
                    clearToSend <= isHeaderless; // [R21]
                    tx_q <= ST_COLLECT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Receive delivery
    // ------------------------------------------------------------------
    hlpf_rx_t rx_q;
    logic keep_q;
    logic append_q;
    wire rxTake = rxValid && rxReady;
    wire rxHdrDest = rxFirst || rx_q == RX_DEST;
    wire destPass = !comm1[hlpf_pkg::C1_DEST_CHK] || rxData == localAddr ||
                    rxData == hlpf_pkg::DEST_BROADCAST; // [R14]
    wire srcPass = !comm1[hlpf_pkg::C1_SRC_CHK] || rxData == destReg; // [R14]
    wire if4Bit = regs_q[hlpf_pkg::OFF_IF4][hlpf_pkg::IF4_CRLF];
    wire wantAppend = isHeaderless ? (if4Bit && !rxData[hlpf_pkg::FLG_HEADERLESS]) : !if4Bit; // [R15] [R16] [R17]

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_q <= RX_DEST;
            keep_q <= 1'b0;
            append_q <= 1'b0;
            rxReady <= 1'b0;
            hostOutValid <= 1'b0;
            hostOutData <= 8'h00;
            rxBinary <= 1'b0;
            headerless <= 1'b0;
            repeaterRole <= 1'b0;
        end else begin
            headerless <= isHeaderless;
            repeaterRole <= regs_q[hlpf_pkg::OFF_COMM2][hlpf_pkg::C2_REPEATER]; // [R19]
            rxBinary <= rxBinary && !isHeaderless; // [R11]
            rxReady <= !(rxTake && rx_q == RX_DATA && rxLast && keep_q && append_q) && rx_q != RX_CR && rx_q != RX_LF;
            hostOutValid <= 1'b0;
            if (rx_q == RX_CR) begin
                hostOutValid <= 1'b1;
                hostOutData <= hlpf_pkg::CHAR_CR;
                rx_q <= RX_LF;
            end else if (rx_q == RX_LF) begin
                hostOutValid <= 1'b1;
                hostOutData <= hlpf_pkg::CHAR_LF;
                rxReady <= 1'b1;
                rx_q <= RX_DEST;
            end else if (rxTake) begin
                if (rxHdrDest) begin
                    keep_q <= destPass;
                    rx_q <= rxLast ? RX_DEST : RX_SRC;
                end else if (rx_q == RX_SRC) begin
                    keep_q <= keep_q && srcPass;
                    rx_q <= rxLast ? RX_DEST : RX_FLAGS;
                end else if (rx_q == RX_FLAGS) begin
                    append_q <= wantAppend;
                    rxBinary <= !isHeaderless && rxData[hlpf_pkg::FLG_BINARY]; // [R10] [R11]
                    rx_q <= rxLast ? RX_DEST : RX_DATA;
                end else begin
                    hostOutValid <= keep_q;
                    hostOutData <= rxData;
                    if (rxLast) begin
                        rx_q <= (keep_q && append_q) ? RX_CR : RX_DEST;
                    end
                end
            end
        end
    end
endmodule : hlpf_framer

// ===== hlpf_framer_props.sv
// Purpose: Port-level assertions for hlpf_framer.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound into hlpf_framer below.
`timescale 1ns/1ps
module hlpf_framer_props (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register side
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic setDestValid,
    input wire logic [7:0] setDestAddr,
    input wire logic readAllCmd,
    input wire logic regRdValid,
    input wire logic cmdOk,
    input wire logic cmdError,
    // Stream side
    input wire logic clearToSend,
    input wire logic pktValid,
    input wire logic [7:0] pktData,
    input wire logic pktLast,
    input wire logic pktReady,
    // Status
    input wire logic rxBinary,
    input wire logic headerless,
    input wire logic repeaterRole
);
    logic [7:0] rdRun_q;
    // Length of the current run of read bytes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdRun_q <= 8'h00;
        end else begin
            rdRun_q <= regRdValid ? rdRun_q + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    AST_RD_ANSWER: assert property (regRead && !readAllCmd && !regRdValid |=> regRdValid)
        else $error("read not answered");
    AST_READALL_28: assert property (readAllCmd |-> ##29 (cmdOk && regRdValid && rdRun_q == 8'd27))
        else $error("read-all short");
    AST_DEST_REFUSE: assert property (setDestValid && setDestAddr > 8'hef && setDestAddr < 8'hff |=> cmdError && !cmdOk)
        else $error("bad destination taken");
    AST_DEST_TAKE: assert property (setDestValid && setDestAddr <= 8'hef |=> cmdOk && !cmdError)
        else $error("destination refused");
    AST_MODE_HL: assert property (regWrite && regAddr == 5'h03 |-> ##2 headerless == ($past(regWdata, 2) == 8'hff))
        else $error("mode flag wrong");
    AST_CTS_ONLY_HL: assert property (!headerless && !$past(headerless) |-> !clearToSend)
        else $error("CTS outside headerless");
    AST_CTS_TX: assert property (pktValid |-> !clearToSend)
        else $error("CTS during transmit");
    AST_PKT_HOLD: assert property (pktValid && !pktReady |=> pktValid && $stable(pktData) && $stable(pktLast))
        else $error("byte changed in stall");
    AST_RPT_ROLE: assert property (regWrite && regAddr == 5'h13 |-> ##2 repeaterRole == $past(regWdata[0], 2))
        else $error("repeater role wrong");
    AST_HL_NO_BIN: assert property (headerless && $past(headerless) |-> !rxBinary)
        else $error("binary tag in headerless");
    COV_READALL: cover property (readAllCmd ##29 cmdOk);
    COV_PKT: cover property (pktValid && pktReady && pktLast);
    COV_REFUSE: cover property (cmdError);
endmodule : hlpf_framer_props

bind hlpf_framer hlpf_framer_props props_u (.*);

// ===== hlpf_host_model.sv
// Purpose: Terminal equipment sending bytes under clear-to-send control.
// Assumes: Bytes change on the falling edge.
// Notes: hung flags a missing clear-to-send.
`timescale 1ns/1ps
module hlpf_host_model (
    // Clock
    input wire logic clk,
    // Flow control
    input wire logic clearToSend,
    // Byte out
    output logic hostValid,
    output logic [7:0] hostData
);
    logic hung = 1'b0;
    initial {hostValid, hostData} = 9'h000;
    task send(input logic [7:0] b);
        int i;
        @(negedge clk);
        hostValid = 1'b1;
        hostData = b;
        for (i = 0; i < 2000; i++) begin
            @(posedge clk);
            if (clearToSend) break;
        end
        if (i == 2000) hung = 1'b1;
        @(negedge clk);
        hostValid = 1'b0;
        hostData = ~b;
    endtask : send
endmodule : hlpf_host_model

// ===== tb_top.sv
// Purpose: Self-checking bench for hlpf_framer.
// Assumes: Short input timeout of 64 cycles, one retry.
// Notes: Inputs change on the falling edge.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin nErrors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
    typedef struct {logic hl; logic [7:0] if4; logic [7:0] c1; logic [7:0] dest; logic [7:0] fl; int n; logic bin;} hlpf_row_t;
    logic clk, resetn, regWrite, regRead, setDestValid, readAllCmd, rxValid, rxFirst, rxLast;
    logic regRdValid, cmdOk, cmdError, clearToSend, hostOutValid, rxBinary, pktValid, pktLast, rxReady;
    logic headerless, repeaterRole, hostValid, pktReady = 1'b0;
    logic [4:0] regAddr;
    logic [7:0] regWdata, setDestAddr, rxData, regRdata, hostOutData, pktData, hostData;
    logic [7:0] pkt[$], hq[$], rdq[$], exp[$];
    int nErrors = 0, numChecks = 0, nLast = 0, nOk = 0, nErr = 0;
    logic [7:0] seq [4][3] = '{'{8'h41, 8'h42, 8'h22}, '{8'h41, 8'h21, 8'h5a}, '{8'h22, 8'h21, 8'h22},
        '{8'h41, 8'h0d, 8'h0a}};
    hlpf_row_t rows [8] = '{'{1'b1, 8'h00, 8'h00, 8'h00, 8'h00, 1, 1'b0}, '{1'b1, 8'h10, 8'h00, 8'h00, 8'h00, 3, 1'b0},
        '{1'b1, 8'h10, 8'h00, 8'h00, 8'h02, 1, 1'b0}, '{1'b1, 8'h00, 8'h01, 8'h07, 8'h00, 0, 1'b0},
        '{1'b1, 8'h00, 8'h01, 8'hff, 8'h01, 1, 1'b0}, '{1'b1, 8'h00, 8'h02, 8'h00, 8'h00, 0, 1'b0},
        '{1'b0, 8'h00, 8'h00, 8'h00, 8'h01, 3, 1'b1}, '{1'b0, 8'h10, 8'h00, 8'h00, 8'h00, 1, 1'b0}};
    initial clk = 1'b0;
    always #50 clk = ~clk;
    hlpf_framer #(.TIMEOUT_CYCLES(64), .RETRIES(1)) dut_u (.*);
    hlpf_host_model host_u (.*);
    // Radio side stalls every other cycle
    always @(negedge clk) pktReady <= ~pktReady;
    always @(posedge clk) begin
        if (pktValid && pktReady) pkt.push_back(pktData);
        if (pktValid && pktReady && pktLast) nLast++;
        if (hostOutValid) hq.push_back(hostOutData);
        if (regRdValid) rdq.push_back(regRdata);
        if (cmdOk) nOk++;
        if (cmdError) nErr++;
    end
    function automatic logic [7:0] rst_val(input int i);
        case (i)
            3: return 8'hf0;
            13: return 8'h1e;
            16, 17: return 8'h32;
            18: return 8'h8c;
            default: return 8'h00;
        endcase
    endfunction : rst_val
    task stop_test;
        if (host_u.hung) nErrors++;
        $display("checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    task cmp_q(input string nm, input logic [7:0] g[$]);
        int i;
        `CHK(nm, exp.size(), g.size())
        for (i = 0; i < exp.size() && i < g.size(); i++) `CHK(nm, exp[i], g[i])
    endtask : cmp_q
    task rg(input logic w, input logic [4:0] a, input logic [7:0] d);
        rdq.delete();
        @(negedge clk);
        {regWrite, regRead, regAddr, regWdata} = {w, !w, a, d};
        @(negedge clk);
        {regWrite, regRead} = 2'b00;
        @(negedge clk);
    endtask : rg
    task sd(input logic [7:0] a);
        @(negedge clk);
        setDestValid = 1'b1;
        setDestAddr = a;
        @(negedge clk);
        setDestValid = 1'b0;
        @(negedge clk);
    endtask : sd
    task wait_last(input int n);
        int i;
        for (i = 0; i < 400 && nLast < n; i++) @(negedge clk);
        if (nLast < n) begin
            nErrors++;
            stop_test();
        end
    endtask : wait_last
    task rx(input logic [7:0] d, input logic [7:0] f);
        logic [7:0] b [4];
        int i, j;
        b = '{d, 8'h33, f, 8'h41};
        for (i = 0; i < 4; i++) begin
            @(negedge clk);
            rxValid = 1'b1;
            rxData = b[i];
            rxFirst = (i == 0);
            rxLast = (i == 3);
            for (j = 0; j < 20; j++) begin
                @(posedge clk);
                if (rxReady) break;
            end
            if (j == 20) nErrors++;
        end
        @(negedge clk);
        rxValid = 1'b0;
        rxData = ~rxData;
    endtask : rx
    initial begin
        int i, k, m;
        {regWrite, regRead, setDestValid, readAllCmd, rxValid, rxFirst, rxLast, resetn} = '0;
        {regAddr, regWdata, setDestAddr, rxData} = '0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        readAllCmd = 1'b1;
        @(negedge clk);
        readAllCmd = 1'b0;
        for (i = 0; i < 60 && rdq.size() < 28; i++) @(negedge clk);
        for (i = 0; i < 28; i++) exp.push_back(rst_val(i));
        cmp_q("readAll", rdq);
        rg(1'b0, 5'h1f, 8'h00);
        exp = '{8'h00};
        cmp_q("unmapped", rdq);
        rg(1'b1, hlpf_pkg::OFF_MODE, 8'hff);
        repeat (2) @(negedge clk);
        `CHK("cts", 1'b1, clearToSend)
        `CHK("hl", 1'b1, headerless)
        rg(1'b1, hlpf_pkg::OFF_COMM1, 8'hff);
        rg(1'b0, hlpf_pkg::OFF_COMM1, 8'h00);
        exp = '{8'hbf};
        cmp_q("comm1", rdq);
        rg(1'b1, hlpf_pkg::OFF_COMM2, 8'h01);
        @(negedge clk);
        `CHK("role", 1'b1, repeaterRole)
        sd(8'hf0);
        sd(8'hfe);
        sd(8'hef);
        sd(8'h05);
        `CHK("refused", 2, nErr)
        `CHK("accepted", 3, nOk)
        rg(1'b0, hlpf_pkg::OFF_DEST, 8'h00);
        exp = '{8'h05};
        cmp_q("dest", rdq);
        rg(1'b1, hlpf_pkg::OFF_RPT, 8'h0a);
        rg(1'b1, hlpf_pkg::OFF_TERM1, 8'h21);
        rg(1'b1, hlpf_pkg::OFF_TERM2, 8'h22);
        for (m = 0; m < 4; m++) begin
            rg(1'b1, hlpf_pkg::OFF_COMM1, {2'b00, m[0], m[1], m[1:0], 2'b00});
            pkt.delete();
            nLast = 0;
            for (k = 0; k < 3; k++) host_u.send(seq[m][k]);
            wait_last(1);
            exp = '{8'h05};
            if (m[0]) exp.push_back(8'h0a);
            exp.push_back({6'h00, 1'b1, m[1]});
            for (k = 0; k < 3; k++) exp.push_back(seq[m][k]);
            cmp_q("packet", pkt);
            repeat (3) @(negedge clk);
            `CHK("ctsBack", 1'b1, clearToSend)
        end
        pkt.delete();
        nLast = 0;
        host_u.send(8'h41);
        repeat (100) @(negedge clk);
        host_u.send(8'h0d);
        host_u.send(8'h0a);
        wait_last(1);
        exp = '{8'h05, 8'h0a, 8'h03, 8'h0d, 8'h0a};
        cmp_q("timeout", pkt);
        sd(8'hff);
        pkt.delete();
        nLast = 0;
        for (k = 0; k < 3; k++) host_u.send(seq[3][k]);
        wait_last(2);
        `CHK("copies", 12, pkt.size())
        sd(8'h05);
        k = nErr;
        for (i = 0; i < 256; i++) host_u.send(8'h41);
        repeat (3) @(negedge clk);
        `CHK("tooLong", k + 1, nErr)
        for (i = 0; i < 8; i++) begin
            rg(1'b1, hlpf_pkg::OFF_MODE, rows[i].hl ? 8'hff : 8'hf0);
            rg(1'b1, hlpf_pkg::OFF_IF4, rows[i].if4);
            rg(1'b1, hlpf_pkg::OFF_COMM1, rows[i].c1);
            hq.delete();
            rx(rows[i].dest, rows[i].fl);
            repeat (6) @(negedge clk);
            exp = '{8'h41, 8'h0d, 8'h0a};
            while (exp.size() > rows[i].n) void'(exp.pop_back());
            cmp_q("rxOut", hq);
            `CHK("rxBinary", rows[i].bin, rxBinary)
        end
        stop_test();
    end
endmodule : tb_top
